/* scalar_decode_pkg.sv */
// shared types and constants for the scalar opcode decoder
package scalar_decode_pkg;

    // ==========================================================
    // instruction word fields
    localparam int WORD_W = 32;
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 24;
    localparam int R_MSB = 23;
    localparam int R_LSB = 20;
    localparam int X_MSB = 19;
    localparam int X_LSB = 16;
    localparam logic [3:0] NOP_GROUP = 4'h0;

    // ==========================================================
    // decoded control encodings
    typedef enum logic [4:0] {
        CLS_NONE, CLS_ADD, CLS_ADD_MAG, CLS_SUB, CLS_SUB_MAG, CLS_MUL, CLS_DIV,
        CLS_LOGIC, CLS_SHIFT, CLS_BIT_REVERSE, CLS_COMPARE, CLS_COMPARE_MASK,
        CLS_LOOP_BRANCH, CLS_SKIP, CLS_PAIR_BRANCH, CLS_STACK, CLS_CONTROL,
        CLS_CONVERT, CLS_SUPERVISOR, CLS_ARRAY, CLS_COND_BRANCH
    } op_class_t;

    typedef enum logic [1:0] {LEN_NONE, LEN_SGL, LEN_HALF, LEN_DBL} len_t;

    typedef enum logic [1:0] {FM_NONE, FM_MEM, FM_IMM, FM_PAIR} form_t;

    typedef enum logic [2:0] {RF_NONE, RF_ARITH, RF_BASE, RF_INDEX, RF_VECTOR} reg_file_t;

    typedef enum logic [3:0] {
        COND_NONE, COND_NEVER, COND_EQ, COND_GT, COND_GE, COND_LT, COND_LE,
        COND_NE, COND_ALWAYS
    } cond_t;

    // per-opcode table entry
    typedef struct packed {
        logic defined;
        op_class_t cls;
        len_t len;
        logic is_float;
        form_t form;
        reg_file_t dst;
        reg_file_t src2;
    } ctl_t;

    // registered decoder output state
    typedef struct packed {
        logic valid;
        logic illegal;
        logic nop;
        op_class_t cls;
        logic [3:0] func;
        len_t len;
        logic is_float;
        form_t form;
        reg_file_t dst_file;
        logic [3:0] dst_num;
        reg_file_t src2_file;
        logic [3:0] src2_num;
        cond_t cond;
        logic preload;
    } dec_state_t;

    localparam dec_state_t DEC_RESET = '0;

endpackage

/* index_file_mapper.sv */
// maps a 4-bit register field onto a register file and number
module index_file_mapper (
    // requested file and raw field
    input scalar_decode_pkg::reg_file_t file_in,
    input wire logic [3:0] field,
    // resolved file and number
    output scalar_decode_pkg::reg_file_t file_out,
    output logic [3:0] num_out
);
    import scalar_decode_pkg::*;

    always_comb begin
        file_out = file_in;
        num_out = field;
        if (file_in == RF_INDEX) begin
            // upper half of the field reaches the vector parameter file
            file_out = field[3] ? RF_VECTOR : RF_INDEX;
            num_out = {1'b0, field[2:0]};
        end
    end

endmodule // index_file_mapper

/* field_condition_decoder.sv */
// decodes the R field of the opcodes that use it as a modifier
module field_condition_decoder (
    // opcode and modifier field
    input wire logic [7:0] opcode,
    input wire logic [3:0] rfield,
    // decoded modifier
    output scalar_decode_pkg::cond_t cond,
    output logic preload,
    output logic field_ok
);
    import scalar_decode_pkg::*;

    always_comb begin
        cond = COND_NONE;
        preload = 1'b0;
        field_ok = 1'b1;
        case (opcode)
            8'h91: begin
                case (rfield)
                    4'h0: cond = COND_NEVER;
                    4'h1: cond = COND_EQ;
                    4'h2: cond = COND_GT;
                    4'h3: cond = COND_GE;
                    4'h4: cond = COND_LT;
                    4'h5: cond = COND_LE;
                    4'h6: cond = COND_NE;
                    4'h7: cond = COND_ALWAYS;
                    default: field_ok = 1'b0;
                endcase
            end
            8'hb0: begin
                case (rfield)
                    4'h0: preload = 1'b1;
                    4'h1: preload = 1'b0;
                    default: field_ok = 1'b0;
                endcase
            end
            default: cond = COND_NONE;
        endcase
    end

endmodule // field_condition_decoder

/* scalar_opcode_decoder.sv */
// scalar instruction opcode decoder, one registered stage
//
// Overview of operation
// - 40/60/62: add memory into A/B/X file
// - 50/70/72: add immediate into A/B/X file
// - 41/51 half add; 42/43 float add
// - 44-47 magnitude add, four lengths
// - 48/58/49/59/4A/4B subtract forms
// - 4C-4F magnitude subtract, four lengths
// - 6C/68/6A multiply memory; 7C/78/7A immediate
// - 6D/7D half, 6E/6F float multiply
// - 64/74/65/75/66/67 divide forms
// - bitwise ops: E0.. memory, F0.. immediate, E1.. double
// - shifts C0/C1/C3, C4/C5/C7, CC/CD/CF by kind, C6 bit reverse
// - compares C8/D8, CE/DE, C9/D9, CA/CB
// - mask compares E2/F2/E3 and E6/F6/E7
// - 88-8B arith, 8C-8F index loop branches
// - 80-83 increment/decrement skip instructions
// - 84-87 pair branches, second register from index
// - 93 push, 97 pull, 9F modify
// - 98/99 branch-link, 56/52 address, 92/96
// - conversions A0-A2, A8-AB, normalize AC/AD
// - 90/94 supervisor calls; B0 array by R
// - 91 R field selects compare-code condition
// - leading opcode nibble zero executes as no-op
// - index file field 8-F selects vector file
module scalar_opcode_decoder (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // from instruction fetch
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_word,
    // issue status
    output logic dec_valid,
    output logic dec_illegal,
    output logic dec_nop,
    // operation
    output scalar_decode_pkg::op_class_t dec_class,
    output logic [3:0] dec_func,
    output scalar_decode_pkg::len_t dec_len,
    output logic dec_float,
    output scalar_decode_pkg::form_t dec_form,
    // registers
    output scalar_decode_pkg::reg_file_t dec_dst_file,
    output logic [3:0] dec_dst_num,
    output scalar_decode_pkg::reg_file_t dec_src2_file,
    output logic [3:0] dec_src2_num,
    // branch and array modifiers
    output scalar_decode_pkg::cond_t dec_cond,
    output logic dec_preload
);
    import scalar_decode_pkg::*;

    // ==========================================================
    // table helpers
    function automatic ctl_t mk(input op_class_t c, input len_t l, input logic f,
                                input form_t fm, input reg_file_t d);
        ctl_t r;
        r.defined = 1'b1;
        r.cls = c;
        r.len = l;
        r.is_float = f;
        r.form = fm;
        r.dst = d;
        r.src2 = RF_NONE;
        return r;
    endfunction

    // low two opcode bits: fixed single, fixed half, float single, float double
    // every caller of this helper writes the arithmetic file
    function automatic ctl_t sized(input op_class_t c, input logic [1:0] sz,
                                   input form_t fm);
        ctl_t r;
        r = mk(c, LEN_SGL, 1'b0, fm, RF_ARITH);
        case (sz)
            2'h1: r.len = LEN_HALF;
            2'h2: r.is_float = 1'b1;
            2'h3: begin
                r.len = LEN_DBL;
                r.is_float = 1'b1;
            end
            default: r.len = LEN_SGL;
        endcase
        return r;
    endfunction

    // ==========================================================
    // opcode table
    function automatic ctl_t decode_op(input logic [7:0] op);
        ctl_t c;
        c = '0;
        case (op)
            // add
            8'h40: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h60: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_MEM, RF_BASE);
            8'h62: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'h50: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'h70: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_IMM, RF_BASE);
            8'h72: c = mk(CLS_ADD, LEN_SGL, 1'b0, FM_IMM, RF_INDEX);
            8'h41: c = sized(CLS_ADD, op[1:0], FM_MEM);
            8'h51: c = sized(CLS_ADD, op[1:0], FM_IMM);
            8'h42: c = sized(CLS_ADD, op[1:0], FM_MEM);
            8'h43: c = sized(CLS_ADD, op[1:0], FM_MEM);
            8'h44: c = sized(CLS_ADD_MAG, op[1:0], FM_MEM);
            8'h45: c = sized(CLS_ADD_MAG, op[1:0], FM_MEM);
            8'h46: c = sized(CLS_ADD_MAG, op[1:0], FM_MEM);
            8'h47: c = sized(CLS_ADD_MAG, op[1:0], FM_MEM);

            // subtract
            8'h48: c = sized(CLS_SUB, op[1:0], FM_MEM);
            8'h58: c = sized(CLS_SUB, op[1:0], FM_IMM);
            8'h49: c = sized(CLS_SUB, op[1:0], FM_MEM);
            8'h59: c = sized(CLS_SUB, op[1:0], FM_IMM);
            8'h4a: c = sized(CLS_SUB, op[1:0], FM_MEM);
            8'h4b: c = sized(CLS_SUB, op[1:0], FM_MEM);
            8'h4c: c = sized(CLS_SUB_MAG, op[1:0], FM_MEM);
            8'h4d: c = sized(CLS_SUB_MAG, op[1:0], FM_MEM);
            8'h4e: c = sized(CLS_SUB_MAG, op[1:0], FM_MEM);
            8'h4f: c = sized(CLS_SUB_MAG, op[1:0], FM_MEM);

            // multiply
            8'h6c: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h68: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_MEM, RF_BASE);
            8'h6a: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'h7c: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'h78: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_IMM, RF_BASE);
            8'h7a: c = mk(CLS_MUL, LEN_SGL, 1'b0, FM_IMM, RF_INDEX);
            8'h6d: c = sized(CLS_MUL, op[1:0], FM_MEM);
            8'h7d: c = sized(CLS_MUL, op[1:0], FM_IMM);
            8'h6e: c = sized(CLS_MUL, op[1:0], FM_MEM);
            8'h6f: c = sized(CLS_MUL, op[1:0], FM_MEM);

            // divide
            8'h64: c = sized(CLS_DIV, op[1:0], FM_MEM);
            8'h74: c = sized(CLS_DIV, op[1:0], FM_IMM);
            8'h65: c = sized(CLS_DIV, op[1:0], FM_MEM);
            8'h75: c = sized(CLS_DIV, op[1:0], FM_IMM);
            8'h66: c = sized(CLS_DIV, op[1:0], FM_MEM);
            8'h67: c = sized(CLS_DIV, op[1:0], FM_MEM);

            // bitwise, func[3:2] picks and/or/xor/equivalence
            8'he0: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'he4: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'he8: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'hec: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'hf0: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hf4: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hf8: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hfc: c = mk(CLS_LOGIC, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'he1: c = mk(CLS_LOGIC, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);
            8'he5: c = mk(CLS_LOGIC, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);
            8'he9: c = mk(CLS_LOGIC, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);
            8'hed: c = mk(CLS_LOGIC, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);

            // shifts, count travels as the immediate; func[3:2] picks kind
            8'hc0: c = mk(CLS_SHIFT, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hc1: c = mk(CLS_SHIFT, LEN_HALF, 1'b0, FM_IMM, RF_ARITH);
            8'hc3: c = mk(CLS_SHIFT, LEN_DBL, 1'b0, FM_IMM, RF_ARITH);
            8'hc4: c = mk(CLS_SHIFT, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hc5: c = mk(CLS_SHIFT, LEN_HALF, 1'b0, FM_IMM, RF_ARITH);
            8'hc7: c = mk(CLS_SHIFT, LEN_DBL, 1'b0, FM_IMM, RF_ARITH);
            8'hcc: c = mk(CLS_SHIFT, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hcd: c = mk(CLS_SHIFT, LEN_HALF, 1'b0, FM_IMM, RF_ARITH);
            8'hcf: c = mk(CLS_SHIFT, LEN_DBL, 1'b0, FM_IMM, RF_ARITH);
            8'hc6: c = mk(CLS_BIT_REVERSE, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);

            // numeric compare
            8'hc8: c = mk(CLS_COMPARE, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'hd8: c = mk(CLS_COMPARE, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'hce: c = mk(CLS_COMPARE, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'hde: c = mk(CLS_COMPARE, LEN_SGL, 1'b0, FM_IMM, RF_INDEX);
            8'hc9: c = sized(CLS_COMPARE, 2'h1, FM_MEM);
            8'hd9: c = sized(CLS_COMPARE, 2'h1, FM_IMM);
            8'hca: c = sized(CLS_COMPARE, op[1:0], FM_MEM);
            8'hcb: c = sized(CLS_COMPARE, op[1:0], FM_MEM);

            // mask compare, func[2] picks and/or
            8'he2: c = mk(CLS_COMPARE_MASK, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'hf2: c = mk(CLS_COMPARE_MASK, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'he3: c = mk(CLS_COMPARE_MASK, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);
            8'he6: c = mk(CLS_COMPARE_MASK, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'hf6: c = mk(CLS_COMPARE_MASK, LEN_SGL, 1'b0, FM_IMM, RF_ARITH);
            8'he7: c = mk(CLS_COMPARE_MASK, LEN_DBL, 1'b0, FM_MEM, RF_ARITH);

            // loop count branches and skips, func[1:0] picks variant
            8'h88, 8'h89, 8'h8a, 8'h8b:
                c = mk(CLS_LOOP_BRANCH, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h8c, 8'h8d, 8'h8e, 8'h8f:
                c = mk(CLS_LOOP_BRANCH, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'h80, 8'h81, 8'h82, 8'h83:
                c = mk(CLS_SKIP, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);

            // register pair branches, func[0] low: less-or-equal
            8'h84, 8'h85: begin
                c = mk(CLS_PAIR_BRANCH, LEN_SGL, 1'b0, FM_PAIR, RF_ARITH);
                c.src2 = RF_ARITH;
            end
            8'h86, 8'h87: begin
                c = mk(CLS_PAIR_BRANCH, LEN_SGL, 1'b0, FM_PAIR, RF_INDEX);
                c.src2 = RF_INDEX;
            end

            // stack
            8'h93: c = mk(CLS_STACK, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h97: c = mk(CLS_STACK, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h9f: c = mk(CLS_STACK, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);

            // program control and address forms
            8'h98: c = mk(CLS_CONTROL, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h99: c = mk(CLS_CONTROL, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'h56: c = mk(CLS_CONTROL, LEN_SGL, 1'b0, FM_MEM, RF_INDEX);
            8'h52: c = mk(CLS_CONTROL, LEN_SGL, 1'b0, FM_MEM, RF_BASE);
            8'h92: c = mk(CLS_CONTROL, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'h96: c = mk(CLS_CONTROL, LEN_NONE, 1'b0, FM_MEM, RF_NONE);

            // conversions, func carries the exact direction
            8'ha0: c = mk(CLS_CONVERT, LEN_SGL, 1'b1, FM_MEM, RF_ARITH);
            8'ha1: c = mk(CLS_CONVERT, LEN_SGL, 1'b1, FM_MEM, RF_ARITH);
            8'ha2: c = mk(CLS_CONVERT, LEN_DBL, 1'b1, FM_MEM, RF_ARITH);
            8'ha8: c = mk(CLS_CONVERT, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'haa: c = mk(CLS_CONVERT, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'ha9: c = mk(CLS_CONVERT, LEN_HALF, 1'b0, FM_MEM, RF_ARITH);
            8'hab: c = mk(CLS_CONVERT, LEN_HALF, 1'b0, FM_MEM, RF_ARITH);
            8'hac: c = mk(CLS_CONVERT, LEN_SGL, 1'b0, FM_MEM, RF_ARITH);
            8'had: c = mk(CLS_CONVERT, LEN_HALF, 1'b0, FM_MEM, RF_ARITH);

            // supervisor, array start, compare code branch
            8'h90: c = mk(CLS_SUPERVISOR, LEN_NONE, 1'b0, FM_IMM, RF_NONE);
            8'h94: c = mk(CLS_SUPERVISOR, LEN_NONE, 1'b0, FM_IMM, RF_NONE);
            8'hb0: c = mk(CLS_ARRAY, LEN_NONE, 1'b0, FM_MEM, RF_NONE);
            8'h91: c = mk(CLS_COND_BRANCH, LEN_NONE, 1'b0, FM_MEM, RF_NONE);
            // unlisted codes keep defined low and report illegal, except the zero-nibble group 00-0F, which reports a no-op
            default: c = '0;
        endcase
        return c;
    endfunction

    // ==========================================================
    // field decode
    dec_state_t st;
    dec_state_t next_st;
    logic [7:0] opcode;
    logic [3:0] rfield;
    logic [3:0] xfield;
    ctl_t ctl;
    reg_file_t dst_file;
    logic [3:0] dst_num;
    reg_file_t src2_file;
    logic [3:0] src2_num;
    cond_t cond;
    logic preload;
    logic field_ok;

    assign opcode = fetch_word[OP_MSB:OP_LSB];
    assign rfield = fetch_word[R_MSB:R_LSB];
    assign xfield = fetch_word[X_MSB:X_LSB];
    assign ctl = decode_op(opcode);

    // both mappers pass RF_NONE through untouched
    index_file_mapper dst_map (
        .file_in(ctl.dst),
        .field(rfield),
        .file_out(dst_file),
        .num_out(dst_num)
    );

    // second register of a pair branch sits in the index field
    index_file_mapper src2_map (
        .file_in(ctl.src2),
        .field(xfield),
        .file_out(src2_file),
        .num_out(src2_num)
    );

    field_condition_decoder cond_dec (
        .opcode(opcode),
        .rfield(rfield),
        .cond(cond),
        .preload(preload),
        .field_ok(field_ok)
    );

    // ==========================================================
    // next state
    always_comb begin
        // idle cycles clear every control, nothing is held over
        next_st = DEC_RESET;
        if (fetch_valid) begin
            if (opcode[7:4] == NOP_GROUP) begin
                // data words and address constants fall through harmlessly
                next_st.valid = 1'b1;
                next_st.nop = 1'b1;
            end else if (ctl.defined && field_ok) begin
                next_st.valid = 1'b1;
                next_st.cls = ctl.cls;
                next_st.func = opcode[3:0];
                next_st.len = ctl.len;
                next_st.is_float = ctl.is_float;
                next_st.form = ctl.form;
                next_st.dst_file = dst_file;
                next_st.dst_num = (dst_file == RF_NONE) ? 4'h0 : dst_num;
                next_st.src2_file = src2_file;
                next_st.src2_num = (src2_file == RF_NONE) ? 4'h0 : src2_num;
                next_st.cond = cond;
                next_st.preload = preload;
                // a never-taken compare-code branch is reported as a no-op
                next_st.nop = (cond == COND_NEVER);
            end else begin
                // controls stay at rest so no unit acts on garbage
                next_st.illegal = 1'b1;
            end
        end
    end

    // fetch arrives on this clock, so no input synchroniser
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= DEC_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    // bare flop bits: the issue stage sees no logic after st
    assign dec_valid = st.valid;
    assign dec_illegal = st.illegal;
    assign dec_nop = st.nop;
    assign dec_class = st.cls;
    assign dec_func = st.func;
    assign dec_len = st.len;
    assign dec_float = st.is_float;
    assign dec_form = st.form;
    assign dec_dst_file = st.dst_file;
    assign dec_dst_num = st.dst_num;
    assign dec_src2_file = st.src2_file;
    assign dec_src2_num = st.src2_num;
    assign dec_cond = st.cond;
    assign dec_preload = st.preload;

endmodule // scalar_opcode_decoder

/* scalar_opcode_decoder_monitor.sv */
// assertion checker for the scalar opcode decoder
module scalar_opcode_decoder_monitor
import scalar_decode_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fetch side
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_word,
    // decoded outputs
    input wire logic dec_valid,
    input wire logic dec_illegal,
    input wire logic dec_nop,
    input op_class_t dec_class,
    input reg_file_t dec_dst_file,
    input wire logic [3:0] dec_dst_num,
    input reg_file_t dec_src2_file,
    input wire logic [3:0] dec_src2_num,
    input cond_t dec_cond,
    input wire logic dec_preload
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic [7:0] op = fetch_word[31:24];
    wire logic [3:0] rf = fetch_word[23:20];
    sequence s_take(logic [7:0] code);
        fetch_valid && op == code;
    endsequence
    chk_one_answer: assert property (fetch_valid |=> dec_valid ^ dec_illegal)
        else $error("no single answer for a fetched word");
    chk_idle_quiet: assert property (!fetch_valid |=> !dec_valid && !dec_illegal)
        else $error("output without a fetched word");
    chk_illegal_quiet: assert property (dec_illegal |-> dec_class == CLS_NONE && !dec_valid)
        else $error("illegal word issued controls");
    chk_add_arith: assert property (s_take(8'h40) |=> dec_class == CLS_ADD
        && dec_dst_file == RF_ARITH && dec_dst_num == $past(rf)) else $error("add decode wrong");
    chk_vector_map: assert property (s_take(8'h62) ##0 rf[3] |=> dec_dst_file == RF_VECTOR
        && dec_dst_num == {1'b0, $past(rf[2:0])}) else $error("vector file mapping wrong");
    chk_nop_group: assert property (fetch_valid && op[7:4] == 4'h0 |=> dec_valid && dec_nop)
        else $error("zero group not a no-op");
    chk_cond_code: assert property (s_take(8'h91) ##0 rf inside {[1:6]} |=>
        dec_valid && dec_cond == cond_t'($past(rf) + 4'h1)) else $error("branch condition wrong");
    chk_array_start: assert property (s_take(8'hb0) ##0 rf < 4'h2 |=>
        dec_valid && dec_preload == ($past(rf) == 4'h0)) else $error("array preload wrong");
    chk_pair_src: assert property (s_take(8'h84) |=> dec_src2_file == RF_ARITH
        && dec_src2_num == $past(fetch_word[19:16])) else $error("pair operand wrong");
endmodule // scalar_opcode_decoder_monitor

bind scalar_opcode_decoder scalar_opcode_decoder_monitor u_mon (.core_clk, .rst, .fetch_valid,
    .fetch_word, .dec_valid, .dec_illegal, .dec_nop, .dec_class, .dec_dst_file, .dec_dst_num,
    .dec_src2_file, .dec_src2_num, .dec_cond, .dec_preload);

/* fetch_source_model.sv */
// behavioural instruction fetch source feeding the decoder
module fetch_source_model (
    // clock
    input wire logic core_clk,
    // fetch outputs
    output logic fetch_valid,
    output logic [31:0] fetch_word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        fetch_valid = 1'b0;
        fetch_word = 32'h0;
    end
    // idle word is scrambled so nothing can lean on a held value
    task automatic issue(input logic v, input logic [31:0] w);
        @(posedge core_clk);
        fetch_valid <= v;
        fetch_word <= v ? w : ~fetch_word;
    endtask
endmodule // fetch_source_model

/* scalar_opcode_decoder_tb.sv */
// self-checking bench for the scalar opcode decoder
module scalar_opcode_decoder_tb import scalar_decode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic v;
        logic il;
        logic np;
        op_class_t c;
        len_t l;
        logic f;
        form_t fm;
        reg_file_t df;
        logic [3:0] dn;
        reg_file_t s2f;
        logic [3:0] sn;
        cond_t cd;
        logic pl;
        logic [3:0] fn;
    } exp_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fetch_valid, dec_valid, dec_illegal, dec_nop, dec_float, dec_preload;
    logic [31:0] fetch_word, w;
    logic [3:0] dec_func, dec_dst_num, dec_src2_num;
    op_class_t dec_class;
    len_t dec_len;
    form_t dec_form;
    reg_file_t dec_dst_file, dec_src2_file;
    cond_t dec_cond;
    int err_count, comparisons, seed;
    exp_t pe;
    logic pfull;
    logic [31:0] pw;
    logic [7:0] pool[41] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h62, 8'h72, 8'h41, 8'h51, 8'h42, 8'h43,
        8'h44, 8'h45, 8'h46, 8'h47, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h6a, 8'h7a, 8'h6d, 8'h7d, 8'h66,
        8'h75, 8'he9, 8'hfc, 8'hc6, 8'hc7, 8'h84, 8'h91, 8'hb0, 8'h07, 8'h14, 8'h95, 8'hff,
        8'h48, 8'h49, 8'h4a, 8'h4b, 8'h58, 8'h59};
    always #10 core_clk = ~core_clk;
    scalar_opcode_decoder u_scalar_opcode_decoder (.core_clk(core_clk), .rst(rst),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word), .dec_valid(dec_valid),
        .dec_illegal(dec_illegal), .dec_nop(dec_nop), .dec_class(dec_class), .dec_func(dec_func),
        .dec_len(dec_len), .dec_float(dec_float), .dec_form(dec_form),
        .dec_dst_file(dec_dst_file), .dec_dst_num(dec_dst_num), .dec_src2_file(dec_src2_file),
        .dec_src2_num(dec_src2_num), .dec_cond(dec_cond), .dec_preload(dec_preload));
    fetch_source_model u_fetch (.core_clk(core_clk), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word));
    // ==========================================================
    // expected decode, full=0 leaves operation fields unchecked
    function automatic exp_t exp_of(input logic [31:0] x, output logic full);
        exp_t e;
        logic [7:0] op;
        logic [3:0] r;
        form_t fmd;
        e = '0;
        op = x[31:24];
        r = x[23:20];
        fmd = op[4] ? FM_IMM : FM_MEM;
        full = 1'b1;
        e.v = 1'b1;
        case (op) inside
            8'h40, 8'h50: {e.c, e.l, e.f, e.fm, e.df} = {CLS_ADD, LEN_SGL, 1'b0, fmd, RF_ARITH};
            8'h60, 8'h70: {e.c, e.l, e.f, e.fm, e.df} = {CLS_ADD, LEN_SGL, 1'b0, fmd, RF_BASE};
            8'h62, 8'h72: {e.c, e.l, e.f, e.fm, e.df} = {CLS_ADD, LEN_SGL, 1'b0, fmd, RF_INDEX};
            8'h41, 8'h51: {e.c, e.l, e.f, e.fm, e.df} = {CLS_ADD, LEN_HALF, 1'b0, fmd, RF_ARITH};
            8'h42, 8'h43: {e.c, e.l, e.f, e.fm, e.df} =
                {CLS_ADD, op[0] ? LEN_DBL : LEN_SGL, 1'b1, fmd, RF_ARITH};
            [8'h44:8'h4f], 8'h58, 8'h59: {e.c, e.l, e.f, e.fm, e.df} =
                {op[3] ? (op[2] ? CLS_SUB_MAG : CLS_SUB) : CLS_ADD_MAG,
                op[0] ? (op[1] ? LEN_DBL : LEN_HALF) : LEN_SGL, op[1], fmd, RF_ARITH};
            8'h6a, 8'h7a: {e.c, e.l, e.f, e.fm, e.df} = {CLS_MUL, LEN_SGL, 1'b0, fmd, RF_INDEX};
            8'h6d, 8'h7d: {e.c, e.l, e.f, e.fm, e.df} = {CLS_MUL, LEN_HALF, 1'b0, fmd, RF_ARITH};
            8'h66, 8'h75: {e.c, e.l, e.f, e.fm, e.df} =
                {CLS_DIV, op[4] ? LEN_HALF : LEN_SGL, ~op[4], fmd, RF_ARITH};
            8'he9, 8'hfc: {e.c, e.l, e.f, e.fm, e.df} =
                {CLS_LOGIC, op[0] ? LEN_DBL : LEN_SGL, 1'b0, fmd, RF_ARITH};
            8'hc6, 8'hc7: {e.c, e.l, e.f, e.fm, e.df} = {op[0] ? CLS_SHIFT : CLS_BIT_REVERSE,
                op[0] ? LEN_DBL : LEN_SGL, 1'b0, FM_IMM, RF_ARITH};
            8'h84: {full, e.s2f, e.sn} = {1'b0, RF_ARITH, x[19:16]};
            8'h91: {full, e.v, e.il, e.np, e.cd} = r[3] ? {4'b0010, COND_NONE} :
                {3'b010, r == 4'h0, cond_t'(r + 4'h1)};
            8'hb0: {full, e.v, e.il, e.pl} = (r < 4'h2) ? {3'b010, r == 4'h0} : 4'b0010;
            [8'h00:8'h0f]: {full, e.np} = 2'b01;
            default: {e.v, e.il} = 2'b01;
        endcase
        if (full && e.v) begin
            e.dn = r;
            if (e.df == RF_INDEX && r[3])
                {e.df, e.dn} = {RF_VECTOR, 1'b0, r[2:0]};
        end
        e.fn = (e.v && op[7:4] != 4'h0) ? op[3:0] : 4'h0;
        return e;
    endfunction
    task automatic step(input logic v, input logic [31:0] x);
        exp_t g;
        u_fetch.issue(v, x);
        @(negedge core_clk);
        g = {dec_valid, dec_illegal, dec_nop, dec_class, dec_len, dec_float, dec_form,
            dec_dst_file, dec_dst_num, dec_src2_file, dec_src2_num, dec_cond, dec_preload,
            dec_func};
        if (!pfull)
            {g.c, g.l, g.f, g.fm, g.df, g.dn} = {pe.c, pe.l, pe.f, pe.fm, pe.df, pe.dn};
        comparisons++;
        if (g !== pe) begin
            err_count++;
            $display("unexpected at %0t: word %h decoded %h, wanted %h", $time, pw, g, pe);
        end
        pe = v ? exp_of(x, pfull) : exp_t'('0);
        pfull = v ? pfull : 1'b1;
        pw = x;
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #2ms;
        err_count++;
        summarize();
    end
    initial begin
        {err_count, comparisons, seed, pe, pfull, pw} =
            {32'd0, 32'd0, 32'd53, exp_t'('0), 33'h100000000};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // back-to-back sweep of every listed opcode, vector half of the field
        foreach (pool[i]) step(1'b1, {pool[i], 4'ha, 4'h7, 16'h5a5a});
        for (int r = 0; r < 16; r++) begin
            step(1'b1, {8'h91, r[3:0], 20'h0});
            step(1'b1, {8'hb0, r[3:0], 20'h0});
        end
        step(1'b0, 32'h0);
        for (int i = 0; i < 400; i++) begin
            w = $random(seed);
            w[31:24] = pool[$unsigned($random(seed)) % 41];
            step(($random(seed) & 7) != 0, w);
        end
        step(1'b0, 32'h0);
        summarize();
    end
endmodule // scalar_opcode_decoder_tb
